// *** include/scsr_pkg.sv ***
// constants, field layout and types for the sensor configuration and soft reset block
// assumes a 250 MHz ref clock and a serial engine on the same clock handing over requests
//
// Operation
// - writing one to reset bit requests reset
// - reset accepted in every operating mode
// - pin polarity, drive, pulse-disable survive reset
// - boot end shown as pulse on irq
// - reset also clears serial interface logic
// - reset waits for transaction end
// - reset bit always reads back zero
// - 300 to 500 us before sequence starts
// - axis field picks self-test axis
// - polarity bit picks displacement sign
// - self-test uses internal stimulus only
// - axis codes: off, x, z
// - polarity zero positive, one negative
// - range codes 2, 4, 8, 16 g
// - bit zero selects standby or active

package scsr_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] SCSR_CFG1_ADDR     = 8'h15;

   // field layout of sensor_config_one, msb first
   typedef struct packed {
      logic       rst_trigger;
      logic [1:0] selftest_axis_select;
      logic       selftest_polarity;
      logic       spi_three_wire;
      logic [1:0] full_scale_range;
      logic       active;
   } scsr_cfg_t;

   localparam scsr_cfg_t SCSR_CFG1_RST_STRAP_LO = 8'h00;
   localparam scsr_cfg_t SCSR_CFG1_RST_STRAP_HI = 8'h03;
   localparam logic [7:0] SCSR_UNMAPPED_RD      = 8'h00;
   localparam logic       SCSR_RST_READ_VAL     = 1'h0;

   // ==========================================================
   // field encodings
   localparam logic [1:0] SCSR_ST_AXIS_OFF = 2'h0;
   localparam logic [1:0] SCSR_ST_AXIS_X   = 2'h1;
   localparam logic [1:0] SCSR_ST_AXIS_Z   = 2'h2;
   localparam logic       SCSR_SELFTEST_POLARITY_POS  = 1'h0;
   localparam logic       SCSR_SELFTEST_POLARITY_NEG  = 1'h1;
   localparam logic [1:0] SCSR_FSR_2G      = 2'h0;
   localparam logic [1:0] SCSR_FSR_4G      = 2'h1;
   localparam logic [1:0] SCSR_FSR_8G      = 2'h2;
   localparam logic [1:0] SCSR_FSR_16G     = 2'h3;
   localparam logic       SCSR_MODE_STBY   = 1'h0;
   localparam logic       SCSR_MODE_ACTIVE = 1'h1;

   // retained pin configuration, cleared only by power-on
   typedef struct packed {
      logic irq_pin_polarity;    // 1: active high
      logic irq_pin_drive_type;  // 1: push-pull, 0: open drain
      logic boot_pulse_disable;
   } scsr_pin_cfg_t;

   localparam scsr_pin_cfg_t SCSR_PIN_CFG_POR = 3'h0;

   // request from the serial engine, one cycle per access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scsr_bus_req_t;

   // ==========================================================
   // timing
   localparam int SCSR_CLK_PERIOD_NS    = 4;
   localparam int SCSR_RST_DLY_MIN_US   = 300;
   localparam int SCSR_RST_DLY_MAX_US   = 500;
   localparam int SCSR_RST_DLY_CYC      =
      (SCSR_RST_DLY_MIN_US * 1000 + SCSR_CLK_PERIOD_NS - 1) / SCSR_CLK_PERIOD_NS;
   localparam int SCSR_RST_DLY_MAX_CYC  = SCSR_RST_DLY_MAX_US * 1000 / SCSR_CLK_PERIOD_NS;
   localparam int SCSR_BOOT_WAIT_A_US   = 1000;
   localparam int SCSR_BOOT_WAIT_CYC    = SCSR_BOOT_WAIT_A_US * 1000 / SCSR_CLK_PERIOD_NS;
   localparam int SCSR_BOOT_PULSE_NS    = 1000;
   localparam int SCSR_BOOT_PULSE_CYC   =
      (SCSR_BOOT_PULSE_NS + SCSR_CLK_PERIOD_NS - 1) / SCSR_CLK_PERIOD_NS;
   localparam int SCSR_TMR_W            = 20;
   localparam logic [1:0] SCSR_SYNC_SETTLE = 2'h2;

   // ==========================================================
   // sequencer states
   typedef enum logic [5:0] {
      SCSR_ST_POR   = 6'h01,
      SCSR_ST_IDLE  = 6'h02,
      SCSR_ST_PEND  = 6'h04,
      SCSR_ST_DELAY = 6'h08,
      SCSR_ST_BOOT  = 6'h10,
      SCSR_ST_PULSE = 6'h20
   } scsr_state_t;

endpackage : scsr_pkg

// *** hdl/scsr_timer.sv ***
// down counter that times one interval after a start pulse
// assumes start only while idle; load value of zero still lasts one cycle
`timescale 1ns/10ps
`default_nettype none

module scsr_timer #(
   parameter int W = 20
) (
   input  wire logic         ref_clk_in,
   input  wire logic         srst_in,
   input  wire logic         start_in,
   input  wire logic [W-1:0] load_in,
   output logic              busy_out,
   output logic              done_out
);

   logic [W-1:0] cnt_reg;
   logic         busy_reg;
   logic         done_reg;
   wire          last_w = (cnt_reg == '0);

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= busy_reg & last_w;
         if (start_in & ~busy_reg) begin
            cnt_reg  <= load_in;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg  <= last_w ? cnt_reg : cnt_reg - 1'b1;
            busy_reg <= ~last_w;
         end
      end
   end

   assign busy_out = busy_reg;
   assign done_out = done_reg;

endmodule : scsr_timer

`default_nettype wire

// *** hdl/scsr_core.sv ***
// sensor_config_one register with the soft reset and boot sequencer
// assumes serial engines on ref_clk_in; chip select and boot strap arrive as raw pins
`timescale 1ns/10ps
`default_nettype none

module scsr_core
   import scsr_pkg::*;
#(
   parameter int RST_DLY_CYC   = scsr_pkg::SCSR_RST_DLY_CYC,
   parameter int BOOT_WAIT_CYC = scsr_pkg::SCSR_BOOT_WAIT_CYC
) (
   input  wire logic                    ref_clk_in,
   input  wire logic                    srst_in,
   input  wire scsr_pkg::scsr_bus_req_t bus_req_in,
   input  wire logic                    i2c_stop_in,
   input  wire logic                    spi_cs_n_in,
   input  wire logic                    boot_mode_strap_in,
   input  wire logic                    pin_cfg_wr_in,
   input  wire scsr_pkg::scsr_pin_cfg_t pin_cfg_in,
   output logic [7:0]                   rd_data_out,
   output scsr_pkg::scsr_cfg_t          cfg_out,
   output scsr_pkg::scsr_pin_cfg_t      pin_cfg_out,
   output logic                         selftest_x_drive_out,
   output logic                         selftest_z_drive_out,
   output logic                         selftest_negative_out,
   output logic                         core_reset_out,
   output logic                         intf_reset_out,
   output logic                         reset_busy_out,
   output logic                         irq_pin_out,
   output logic                         irq_pin_oe_out
);

   import scsr_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic cs_prev_reg;
   logic strap_meta_reg;
   logic strap_sync_reg;
   logic [1:0] settle_reg;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cs_meta_reg    <= 1'b1;
         cs_sync_reg    <= 1'b1;
         cs_prev_reg    <= 1'b1;
         strap_meta_reg <= 1'b0;
         strap_sync_reg <= 1'b0;
      end else begin
         cs_meta_reg    <= spi_cs_n_in;
         cs_sync_reg    <= cs_meta_reg;
         cs_prev_reg    <= cs_sync_reg;
         strap_meta_reg <= boot_mode_strap_in;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // end of transaction: i2c stop or chip select released
   wire cs_release_w = cs_sync_reg & ~cs_prev_reg;
   wire xfer_end_w   = i2c_stop_in | cs_release_w;

   // ==========================================================
   // sequencer state
   scsr_state_t   state_reg;
   scsr_state_t   state_next;
   scsr_cfg_t     cfg_reg;
   scsr_cfg_t     cfg_next;
   scsr_pin_cfg_t pin_cfg_reg;
   logic [7:0]    rd_data_reg;
   logic          core_rst_reg;
   logic          core_rst_next;

   wire dly_busy_w;
   wire dly_done_w;
   wire boot_busy_w;
   wire boot_done_w;
   wire pls_busy_w;
   wire pls_done_w;

   // defaults follow the strap as caught after reset release
   wire scsr_cfg_t dflt_cfg_w = strap_sync_reg ? SCSR_CFG1_RST_STRAP_HI
                                               : SCSR_CFG1_RST_STRAP_LO;

   // ==========================================================
   // register access decode
   wire st_idle_w   = (state_reg == SCSR_ST_IDLE);
   wire st_pend_w   = (state_reg == SCSR_ST_PEND);
   wire st_delay_w  = (state_reg == SCSR_ST_DELAY);
   wire st_boot_w   = (state_reg == SCSR_ST_BOOT);
   wire st_pulse_w  = (state_reg == SCSR_ST_PULSE);
   wire st_por_w    = (state_reg == SCSR_ST_POR);
   // interface is held in reset from the reload through the boot wait
   wire intf_held_w = st_por_w | st_boot_w;
   wire hit_w       = (bus_req_in.addr == SCSR_CFG1_ADDR);
   // accepted in any sensor mode; only the power-on settle and the boot window block the bus
   wire wr_hit_w    = bus_req_in.wr & hit_w & ~intf_held_w;
   wire rd_hit_w    = bus_req_in.rd & hit_w & ~intf_held_w;
   wire scsr_cfg_t wr_cfg_w = scsr_cfg_t'(bus_req_in.wdata);
   wire rst_req_w   = wr_hit_w & wr_cfg_w.rst_trigger;
   wire strap_ok_w  = (settle_reg == SCSR_SYNC_SETTLE);

   // ==========================================================
   // next state
   always_comb begin
      state_next    = state_reg;
      core_rst_next = 1'b0;
      unique case (state_reg)
         SCSR_ST_POR: begin
            if (strap_ok_w) begin
               state_next = SCSR_ST_BOOT;
            end
         end
         SCSR_ST_IDLE: begin
            if (rst_req_w) begin
               state_next = SCSR_ST_PEND;
            end
         end
         SCSR_ST_PEND: begin
            if (xfer_end_w) begin
               state_next = SCSR_ST_DELAY;
            end
         end
         SCSR_ST_DELAY: begin
            if (dly_done_w) begin
               state_next    = SCSR_ST_BOOT;
               core_rst_next = 1'b1;
            end
         end
         SCSR_ST_BOOT: begin
            if (boot_done_w) begin
               state_next = pin_cfg_reg.boot_pulse_disable ? SCSR_ST_IDLE
                                                           : SCSR_ST_PULSE;
            end
         end
         SCSR_ST_PULSE: begin
            if (pls_done_w) begin
               state_next = SCSR_ST_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // register contents
   always_comb begin
      cfg_next = cfg_reg;
      if (core_rst_next | (st_por_w & strap_ok_w)) begin
         cfg_next = dflt_cfg_w;
      end else if (wr_hit_w) begin
         cfg_next = wr_cfg_w;
      end
      // the trigger is never stored; pending lives in the sequencer
      cfg_next.rst_trigger = SCSR_RST_READ_VAL;
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_reg    <= SCSR_ST_POR;
         cfg_reg      <= SCSR_CFG1_RST_STRAP_LO;
         settle_reg   <= '0;
         core_rst_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cfg_reg      <= cfg_next;
         core_rst_reg <= core_rst_next;
         if (st_por_w & ~strap_ok_w) begin
            settle_reg <= settle_reg + 2'h1;
         end
      end
   end

   // retained pin bits: only power-on clears them
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         pin_cfg_reg <= SCSR_PIN_CFG_POR;
      end else if (pin_cfg_wr_in) begin
         pin_cfg_reg <= pin_cfg_in;
      end
   end

   // read data; reset bit reads zero since the store holds zero
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rd_data_reg <= SCSR_UNMAPPED_RD;
      end else if (bus_req_in.rd) begin
         rd_data_reg <= rd_hit_w ? 8'(cfg_reg) : SCSR_UNMAPPED_RD;
      end
   end

   // ==========================================================
   // interval timers
   // the delay uses the least figure, at the lower end of the allowed window
   scsr_timer #(
      .W (SCSR_TMR_W)
   ) u_dly_tmr (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .start_in   (st_pend_w & xfer_end_w),
      .load_in    (SCSR_TMR_W'(RST_DLY_CYC - 2)),
      .busy_out   (dly_busy_w),
      .done_out   (dly_done_w)
   );

   scsr_timer #(
      .W (SCSR_TMR_W)
   ) u_boot_tmr (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .start_in   (st_boot_w & ~boot_busy_w & ~boot_done_w),
      .load_in    (SCSR_TMR_W'(BOOT_WAIT_CYC - 2)),
      .busy_out   (boot_busy_w),
      .done_out   (boot_done_w)
   );

   scsr_timer #(
      .W (SCSR_TMR_W)
   ) u_pls_tmr (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .start_in   (st_pulse_w & ~pls_busy_w & ~pls_done_w),
      .load_in    (SCSR_TMR_W'(SCSR_BOOT_PULSE_CYC - 2)),
      .busy_out   (pls_busy_w),
      .done_out   (pls_done_w)
   );

   // ==========================================================
   // irq pin: boot pulse honours polarity and drive type
   wire irq_act_w = st_pulse_w;
   wire irq_lvl_w = irq_act_w ? pin_cfg_reg.irq_pin_polarity
                              : ~pin_cfg_reg.irq_pin_polarity;
   // open drain can only pull low, so it drives only a low level
   wire irq_oe_w  = pin_cfg_reg.irq_pin_drive_type | ~irq_lvl_w;

   logic irq_lvl_reg;
   logic irq_oe_reg;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         irq_lvl_reg <= 1'b1;
         irq_oe_reg  <= 1'b0;
      end else begin
         irq_lvl_reg <= irq_lvl_w;
         irq_oe_reg  <= irq_oe_w;
      end
   end

   // ==========================================================
   // outputs
   assign rd_data_out           = rd_data_reg;
   assign cfg_out               = cfg_reg;
   assign pin_cfg_out           = pin_cfg_reg;
   // stimulus is generated inside; no outside motion is needed
   assign selftest_x_drive_out  = (cfg_reg.selftest_axis_select == SCSR_ST_AXIS_X);
   assign selftest_z_drive_out  = (cfg_reg.selftest_axis_select == SCSR_ST_AXIS_Z);
   assign selftest_negative_out = (cfg_reg.selftest_polarity == SCSR_SELFTEST_POLARITY_NEG);
   assign core_reset_out        = core_rst_reg;
   assign intf_reset_out        = intf_held_w;
   assign reset_busy_out        = ~st_idle_w;
   assign irq_pin_out           = irq_lvl_reg;
   assign irq_pin_oe_out        = irq_oe_reg;
   // full_scale_range and active leave on cfg_out unchanged
   wire unused_w = st_delay_w | dly_busy_w;

endmodule : scsr_core

`default_nettype wire

// *** bench/scsr_chk.sv ***
// checker for the sensor config and soft reset core
// assumes bound onto scsr_core; sees only its ports
`timescale 1ns/10ps
`default_nettype none

module scsr_chk
   import scsr_pkg::*;
#(
   parameter int RST_DLY_CYC   = 20,
   parameter int BOOT_WAIT_CYC = 20
) (
   input wire logic                    ref_clk_in,
   input wire logic                    srst_in,
   input wire scsr_pkg::scsr_bus_req_t bus_req_in,
   input wire logic                    i2c_stop_in,
   input wire logic                    spi_cs_n_in,
   input wire logic                    boot_mode_strap_in,
   input wire logic                    pin_cfg_wr_in,
   input wire logic [7:0]              rd_data_out,
   input wire scsr_pkg::scsr_cfg_t     cfg_out,
   input wire scsr_pkg::scsr_pin_cfg_t pin_cfg_out,
   input wire logic                    selftest_x_drive_out,
   input wire logic                    selftest_z_drive_out,
   input wire logic                    selftest_negative_out,
   input wire logic                    core_reset_out,
   input wire logic                    intf_reset_out,
   input wire logic                    reset_busy_out,
   input wire logic                    irq_pin_out,
   input wire logic                    irq_pin_oe_out
);
   // ==========================================================
   // helpers: cycles since the last frame end, saturating
   localparam int LO = RST_DLY_CYC - 1;
   logic        cs_q_reg;
   logic [19:0] cnt_reg;
   wire hit    = (bus_req_in.addr == SCSR_CFG1_ADDR) & ~intf_reset_out;
   wire wr_hit = bus_req_in.wr & hit;
   wire rd_hit = bus_req_in.rd & hit;
   wire end_ev = i2c_stop_in | (spi_cs_n_in & ~cs_q_reg);

   always_ff @(posedge ref_clk_in) begin
      cs_q_reg <= spi_cs_n_in;
      cnt_reg  <= (srst_in) ? 20'hfffff : (end_ev ? 20'h0 : cnt_reg + {19'h0, ~&cnt_reg});
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   // ==========================================================
   // properties
   a_rst_reads_zero: assert property (bus_req_in.rd |=> rd_data_out[7] == 1'b0)
      else $error("reset bit read back as one");
   a_write_lands: assert property (wr_hit |=> cfg_out[6:0] == $past(bus_req_in.wdata[6:0]))
      else $error("write not stored");
   a_read_returns: assert property (rd_hit |=> rd_data_out == {1'b0, $past(cfg_out[6:0])})
      else $error("read data differs from register");
   a_axis_decode: assert property (selftest_x_drive_out == (cfg_out.selftest_axis_select == 2'h1) && selftest_z_drive_out == (cfg_out.selftest_axis_select == 2'h2))
      else $error("axis decode wrong");
   a_polarity_decode: assert property (cfg_out.selftest_axis_select != 2'h0 |-> selftest_negative_out == cfg_out.selftest_polarity)
      else $error("polarity decode wrong");
   a_reset_pends: assert property (wr_hit && bus_req_in.wdata[7] |=> reset_busy_out)
      else $error("reset request not pending");
   a_delay_after_end: assert property (core_reset_out |-> cnt_reg >= LO && cnt_reg != 20'hfffff)
      else $error("reset began too early or without frame end");
   a_reload_defaults: assert property (core_reset_out |-> ##[0:1] cfg_out == (boot_mode_strap_in ? 8'h03 : 8'h00))
      else $error("defaults not reloaded");
   a_intf_reset: assert property (core_reset_out |-> ##[0:1] intf_reset_out)
      else $error("interface not held in reset");
   a_pins_keep: assert property (!pin_cfg_wr_in |=> pin_cfg_out == $past(pin_cfg_out))
      else $error("retained pin bits changed");
   a_boot_pulse: assert property ($fell(reset_busy_out) && !pin_cfg_out.boot_pulse_disable |-> $past(irq_pin_out) == pin_cfg_out.irq_pin_polarity)
      else $error("no boot pulse before idle");
   // push-pull always drives; open drain drives only its low level
   a_irq_drive_en: assert property (irq_pin_oe_out == ($past(pin_cfg_out.irq_pin_drive_type) | ~irq_pin_out))
      else $error("irq pin output enable wrong");
endmodule : scsr_chk

bind scsr_core scsr_chk #(.RST_DLY_CYC(RST_DLY_CYC), .BOOT_WAIT_CYC(BOOT_WAIT_CYC)) u_scsr_chk (
   .ref_clk_in(ref_clk_in), .srst_in(srst_in), .bus_req_in(bus_req_in),
   .i2c_stop_in(i2c_stop_in), .spi_cs_n_in(spi_cs_n_in), .boot_mode_strap_in(boot_mode_strap_in),
   .pin_cfg_wr_in(pin_cfg_wr_in), .rd_data_out(rd_data_out), .cfg_out(cfg_out),
   .pin_cfg_out(pin_cfg_out), .selftest_x_drive_out(selftest_x_drive_out),
   .selftest_z_drive_out(selftest_z_drive_out), .selftest_negative_out(selftest_negative_out),
   .core_reset_out(core_reset_out), .intf_reset_out(intf_reset_out),
   .reset_busy_out(reset_busy_out), .irq_pin_out(irq_pin_out),
   .irq_pin_oe_out(irq_pin_oe_out)
);

`default_nettype wire

// *** bench/scsr_host_model.sv ***
// host model: register accesses, frame ends and the boot wait
// assumes it drives on the falling edge of the core clock
`timescale 1ns/10ps
`default_nettype none

module scsr_host_model
   import scsr_pkg::*;
(
   input  wire logic               ref_clk_in,
   input  wire logic [7:0]         rd_data_in,
   input  wire logic               busy_in,
   input  wire logic               irq_in,
   input  wire logic               pol_in,
   output scsr_pkg::scsr_bus_req_t bus_req_out,
   output logic                    i2c_stop_out,
   output logic                    spi_cs_n_out
);
   initial begin
      bus_req_out  = '0;
      i2c_stop_out = 1'b0;
      spi_cs_n_out = 1'b1;
   end

   // ==========================================================
   // one access, held across one rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge ref_clk_in);
      spi_cs_n_out = 1'b0;
      bus_req_out  = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge ref_clk_in);
      // released lines carry the inverse, never a stale copy
      bus_req_out  = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(negedge ref_clk_in);
      q = rd_data_in;
   endtask : xfer

   task automatic frame_end(input logic spi);
      @(negedge ref_clk_in);
      if (spi) spi_cs_n_out = 1'b1;
      else i2c_stop_out = 1'b1;
      @(negedge ref_clk_in);
      i2c_stop_out = 1'b0;
   endtask : frame_end

   // no traffic until the pulse and the idle state, bounded
   task automatic wait_boot(output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 2000 && !ok; n++) begin
         @(negedge ref_clk_in);
         ok = (irq_in === pol_in);
      end
      for (n = 0; n < 400 && busy_in !== 1'b0; n++) @(negedge ref_clk_in);
      ok = ok & (busy_in === 1'b0);
   endtask : wait_boot
endmodule : scsr_host_model

`default_nettype wire

// *** bench/tb_top.sv ***
// testbench for scsr_core with short delay and boot counts
// assumes the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import scsr_pkg::*;
   localparam int DLY = 20;
   logic          ref_clk_in;
   logic          srst_in;
   logic          strap;
   logic          pin_wr;
   scsr_pin_cfg_t pin_cfg;
   scsr_bus_req_t bus_req;
   logic          i2c_stop;
   logic          cs_n;
   logic [7:0]    rd_data;
   scsr_cfg_t     cfg;
   scsr_pin_cfg_t pin_out;
   logic          st_x, st_z, st_neg, core_rst, intf_rst, busy, irq;
   int            fails = 0;
   int            n_tests = 0;

   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end

   scsr_core #(.RST_DLY_CYC(DLY), .BOOT_WAIT_CYC(20)) u_scsr_core (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .bus_req_in(bus_req),
      .i2c_stop_in(i2c_stop), .spi_cs_n_in(cs_n), .boot_mode_strap_in(strap),
      .pin_cfg_wr_in(pin_wr), .pin_cfg_in(pin_cfg), .rd_data_out(rd_data), .cfg_out(cfg),
      .pin_cfg_out(pin_out), .selftest_x_drive_out(st_x), .selftest_z_drive_out(st_z),
      .selftest_negative_out(st_neg), .core_reset_out(core_rst), .intf_reset_out(intf_rst),
      .reset_busy_out(busy), .irq_pin_out(irq), .irq_pin_oe_out());

   scsr_host_model u_scsr_host_model (
      .ref_clk_in(ref_clk_in), .rd_data_in(rd_data), .busy_in(busy), .irq_in(irq),
      .pol_in(pin_out.irq_pin_polarity), .bus_req_out(bus_req), .i2c_stop_out(i2c_stop),
      .spi_cs_n_out(cs_n));

   // ==========================================================
   // compare and verdict
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // scenarios
   task automatic t_power_on(input logic s);
      logic ok;
      @(negedge ref_clk_in);
      strap   = s;
      srst_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      srst_in = 1'b0;
      u_scsr_host_model.wait_boot(ok);
      chk("boot", {7'h0, ok}, 8'h1);
      chk("por", cfg, s ? 8'h03 : 8'h00);
      chk("pins", {5'h0, pin_out}, 8'h0);
   endtask : t_power_on

   task automatic t_fields;
      logic [7:0] v, q;
      logic [1:0] ax;
      for (int a = 0; a < 3; a++) begin
         for (int f = 0; f < 8; f++) begin
            ax = a[1:0];
            v  = {1'b0, ax, f[2], f[0], f[1:0], f[2] ^ f[0]};
            u_scsr_host_model.xfer(1'b1, SCSR_CFG1_ADDR, v, q);
            u_scsr_host_model.xfer(1'b0, SCSR_CFG1_ADDR, 8'h0, q);
            chk("readback", q, v);
            chk("cfg", cfg, v);
            chk("axis", {6'h0, st_x, st_z}, {6'h0, ax == 2'h1, ax == 2'h2});
            if (ax != 2'h0) chk("neg", {7'h0, st_neg}, {7'h0, f[2]});
         end
      end
      u_scsr_host_model.xfer(1'b0, 8'h16, 8'h0, q);
      chk("unmapped", q, 8'h00);
   endtask : t_fields

   task automatic t_soft(input logic spi, input logic act);
      logic [7:0] v, q;
      logic       hit, ok;
      int         n;
      v   = {1'b1, 2'h1, 1'b1, 1'b0, 2'h2, act};
      hit = 1'b0;
      u_scsr_host_model.xfer(1'b1, SCSR_CFG1_ADDR, v, q);
      u_scsr_host_model.xfer(1'b0, SCSR_CFG1_ADDR, 8'h0, q);
      chk("rst_bit", q, {1'b0, v[6:0]});
      repeat (60) begin
         @(negedge ref_clk_in);
         hit |= core_rst;
      end
      chk("held", {6'h0, hit, busy}, 8'h1);
      u_scsr_host_model.frame_end(spi);
      for (n = 0; n < 200 && core_rst !== 1'b1; n++) @(negedge ref_clk_in);
      // chip select release reaches the core two cycles late through its synchroniser
      chk("delay", {7'h0, n >= DLY - 1 && n <= DLY + 3}, 8'h1);
      chk("reload", cfg, 8'h00);
      chk("pins", {5'h0, pin_out}, 8'h6);
      chk("intf", {7'h0, intf_rst}, 8'h1);
      u_scsr_host_model.wait_boot(ok);
      chk("pulse", {7'h0, ok}, 8'h1);
   endtask : t_soft

   // ==========================================================
   // main sequence and watchdog
   initial begin
      srst_in = 1'b1;
      strap   = 1'b0;
      pin_wr  = 1'b0;
      pin_cfg = '0;
      t_power_on(1'b0);
      t_fields();
      @(negedge ref_clk_in);
      pin_cfg = 3'h6;
      pin_wr  = 1'b1;
      @(negedge ref_clk_in);
      pin_wr  = 1'b0;
      t_soft(1'b0, 1'b1);
      t_soft(1'b1, 1'b0);
      t_power_on(1'b1);
      print_verdict();
   end

   initial begin
      #40000;
      fails++;
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
